// [logic/sps_link_if.sv]
// Link between the power-save master end and slave end
`timescale 1ns/10ps
interface sps_link_if;
    logic link_clk; // Serial clock, master driven, mode 0 idle low
    logic slave_select_n; // Select, master driven, active low
    logic mosi; // Data master to slave
    logic miso_o; // Slave data out
    logic miso_oe_n; // Slave data enable, low while driving
    logic access_req_o; // Slave access request / interrupt level
    logic access_req_oe_n; // Request enable, low while driving
    modport slave_end (
        input link_clk,
        input slave_select_n,
        input mosi,
        output miso_o,
        output miso_oe_n,
        output access_req_o,
        output access_req_oe_n
    );
    modport master_end (
        output link_clk,
        output slave_select_n,
        output mosi,
        input miso_o,
        input miso_oe_n,
        input access_req_o,
        input access_req_oe_n
    );
endinterface

// [logic/sps_master.sv]
// Master end: wakes slave, holds resume time, clocks at 1 MHz
`timescale 1ns/10ps
module sps_master
    import sps_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    sps_link_if.master_end link,
    input wire logic start, // Pulse: begin one transfer
    input wire logic [7:0] resume_time, // Slave resume time, us
    input wire logic [7:0] bit_count, // Clock cycles (bits) to send; twice as many edges
    input wire logic tx_bit, // Data bit to send
    output logic busy, // Level: transfer in progress
    output logic wake_seen_req // Level: slave request seen
);
    typedef enum logic [1:0] {
        SPM_IDLE,
        SPM_RESUME,
        SPM_CLOCK
    } spm_state_t;
    typedef struct packed {
        logic [1:0] req_sync; // Request synchroniser
        spm_state_t state; // Master state
        logic [15:0] cnt; // Wait / half period counter
        logic [8:0] edges; // Remaining half periods
        logic sck; // Link clock out
        logic ss_n; // Select out
        logic mosi; // Data out
    } spm_t;

    spm_t m_r;
    spm_t m_nxt;

    // ==========================================
    // Next state
    always_comb
    begin
        m_nxt = m_r;
        m_nxt.req_sync = {m_r.req_sync[0], ~link.access_req_oe_n};
        case (m_r.state)
            SPM_IDLE:
            begin
                m_nxt.sck = 1'b0; // Mode zero idle
                m_nxt.ss_n = 1'b1;
                if (start)
                begin
                    m_nxt.ss_n = 1'b0;
                    m_nxt.cnt = 16'({8'h00, resume_time} * 16'(CLK_HZ / 1000000));
                    m_nxt.edges = {bit_count, 1'b0};
                    m_nxt.state = SPM_RESUME;
                end
            end
            SPM_RESUME:
            begin
                // Hold select for the resume time
                if (m_r.cnt == 16'h0000)
                begin
                    m_nxt.cnt = 16'(LINK_HALF_CYCLES - 1);
                    m_nxt.mosi = tx_bit;
                    m_nxt.state = SPM_CLOCK;
                end
                else
                begin
                    m_nxt.cnt = m_r.cnt - 16'h0001;
                end
            end
            SPM_CLOCK:
            begin
                // Half periods at the 1 MHz rate
                if (m_r.cnt != 16'h0000)
                begin
                    m_nxt.cnt = m_r.cnt - 16'h0001;
                end
                else if (m_r.edges == 9'h000)
                begin
                    m_nxt.ss_n = 1'b1;
                    m_nxt.sck = 1'b0;
                    m_nxt.state = SPM_IDLE;
                end
                else
                begin
                    m_nxt.cnt = 16'(LINK_HALF_CYCLES - 1);
                    m_nxt.sck = ~m_r.sck;
                    m_nxt.edges = m_r.edges - 9'h001;
                    if (m_r.sck)
                    begin
                        m_nxt.mosi = tx_bit;
                    end
                end
            end
            default:
            begin
                m_nxt.state = SPM_IDLE;
            end
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            m_r <= '{req_sync: 2'b00, state: SPM_IDLE, cnt: 16'h0000, edges: 9'h000,
                     sck: 1'b0, ss_n: 1'b1, mosi: 1'b0};
        end
        else
        begin
            m_r <= m_nxt;
        end
    end

    assign link.link_clk = m_r.sck;
    assign link.slave_select_n = m_r.ss_n;
    assign link.mosi = m_r.mosi;
    assign busy = (m_r.state != SPM_IDLE);
    assign wake_seen_req = m_r.req_sync[1];
endmodule

// [logic/sps_pkg.sv]
// Shared constants and types for the serial-link power-save ends
package sps_pkg;
    // ==========================================
    // Timing
    localparam int unsigned CLK_HZ = 25000000; // System clock rate
    localparam int unsigned POWER_ON_TIME_MS = 1000; // Power-on time before setup
    localparam int unsigned SETUP_WAIT_TIMEOUT_MS = 1000; // Setup wait after power-on
    localparam int unsigned TICK_US = 1000; // Millisecond tick period in us
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US; // Cycles per ms tick
    localparam int unsigned LINK_CLK_HZ = 1000000; // Serial clock rate after resume
    localparam int unsigned LINK_HALF_CYCLES = CLK_HZ / LINK_CLK_HZ / 2; // Half period of link clk
    // ==========================================
    // Setup fields
    localparam logic [15:0] INACT_NONE = 16'hffff; // Inactivity value declining power save
    localparam logic [15:0] INACT_RESET = 16'hffff; // Reset value of negotiated period
    localparam logic [7:0] RESUME_RESET = 8'h80; // Reset value of resume time in us
    // ==========================================
    // Slave power state
    typedef enum logic [1:0] {
        SPS_ST_POWERUP,
        SPS_ST_DESEL,
        SPS_ST_SEL,
        SPS_ST_SAVE
    } sps_state_t;
endpackage

// [logic/sps_slave.sv]
// Slave end: power-save entry and resume control
//
// Operation
// - All-ones inactivity period forbids power saving once deselected
// - Echo master's all-ones period in setup reply
// - Answer every setup request with setup reply
// - Enter power save after end-of-operation acknowledged
// - In power save drive no data, no request
// - No select within power-on plus setup wait time: power save
// - Master idles mode-zero signals before waking
// - Select leading edge resumes to selected state
// - Master holds select for resume time first
// - Master clocks at 1 MHz; slave ready
// - Select release returns to deselected state
// - Master end drives clock and select; slave end does not
// - Acked frames plus inactivity period: power save
// - Pending own access request blocks power save once deselected
`timescale 1ns/10ps
module sps_slave
    import sps_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    sps_link_if.slave_end link,
    input wire logic setup_request_frame, // Pulse: setup request decoded
    input wire logic [15:0] req_inactivity_period, // Period asked by master, ms
    output logic setup_reply_frame, // Pulse: send setup reply
    output logic [15:0] inactivity_period, // Period reported in reply, ms
    output logic [7:0] resume_time, // Resume time reported in reply, us
    input wire logic end_of_operation_event, // Pulse: end event sent
    input wire logic end_of_operation_acked, // Pulse: master acked end event
    input wire logic frames_acked, // Level: no unacked frames
    input wire logic access_request, // Level: slave wants the master
    input wire logic tx_bit, // Data bit to shift out
    output logic power_save, // Level: in power saving mode
    output logic selected, // Level: in selected state
    output logic ready_rx // Level: ready to receive data
);
    // ==========================================
    // State record
    typedef struct packed {
        logic [1:0] clk_sync; // Link clock synchroniser
        logic [1:0] sel_sync; // Select synchroniser
        logic sel_d; // Delayed synchronised select
        sps_state_t state; // Power state
        logic [15:0] tick; // Cycle count within one ms
        logic [15:0] ms; // Inactivity ms counter
        logic [15:0] period; // Negotiated inactivity period
        logic eoo_pend; // End event sent, awaiting ack
        logic reply; // Reply pulse
        logic miso; // Registered data out
    } sps_slv_t;

    sps_slv_t s_r;
    sps_slv_t s_nxt;
    logic sel_now; // Synchronised select asserted
    logic sel_rise; // Select leading edge
    logic ms_tick; // One ms elapsed

    assign sel_now = ~s_r.sel_sync[1];
    assign sel_rise = sel_now & ~s_r.sel_d;
    assign ms_tick = (s_r.tick == 16'(TICK_CYCLES - 1));

    // ==========================================
    // Next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.clk_sync = {s_r.clk_sync[0], link.link_clk};
        s_nxt.sel_sync = {s_r.sel_sync[0], link.slave_select_n};
        s_nxt.sel_d = sel_now;
        s_nxt.reply = 1'b0;
        // Millisecond prescaler
        s_nxt.tick = ms_tick ? 16'h0000 : s_r.tick + 16'h0001;
        if (ms_tick && s_r.ms != 16'hffff)
        begin
            s_nxt.ms = s_r.ms + 16'h0001;
        end
        // Select restarts the inactivity count
        if (sel_now)
        begin
            s_nxt.ms = 16'h0000;
            s_nxt.tick = 16'h0000;
        end
        // Setup request answered with echoed period
        if (setup_request_frame)
        begin
            s_nxt.reply = 1'b1;
            s_nxt.period = req_inactivity_period;
        end
        if (end_of_operation_event)
        begin
            s_nxt.eoo_pend = 1'b1;
        end
        if (sel_now && s_r.clk_sync[1] && s_r.state == SPS_ST_SEL)
        begin
            s_nxt.miso = tx_bit;
        end
        case (s_r.state)
            SPS_ST_POWERUP:
            begin
                // Waiting for first select
                if (sel_rise)
                begin
                    s_nxt.state = SPS_ST_SEL;
                end
                else if (s_r.ms >= 16'(POWER_ON_TIME_MS + SETUP_WAIT_TIMEOUT_MS))
                begin
                    s_nxt.state = SPS_ST_SAVE;
                end
            end
            SPS_ST_DESEL:
            begin
                if (sel_rise)
                begin
                    s_nxt.state = SPS_ST_SEL;
                end
                else if (access_request)
                begin
                    s_nxt.state = SPS_ST_DESEL;
                end
                else if (s_r.period == INACT_NONE)
                begin
                    s_nxt.state = SPS_ST_DESEL;
                end
                else if (s_r.eoo_pend && end_of_operation_acked)
                begin
                    s_nxt.state = SPS_ST_SAVE;
                    s_nxt.eoo_pend = 1'b0;
                end
                else if (frames_acked && s_r.ms >= s_r.period)
                begin
                    s_nxt.state = SPS_ST_SAVE;
                end
            end
            SPS_ST_SEL:
            begin
                // Data phase; release ends it
                if (!sel_now)
                begin
                    s_nxt.state = SPS_ST_DESEL;
                end
            end
            SPS_ST_SAVE:
            begin
                s_nxt.miso = 1'b0;
                if (sel_rise)
                begin
                    s_nxt.state = SPS_ST_SEL;
                end
            end
            default:
            begin
                s_nxt.state = SPS_ST_POWERUP;
            end
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            s_r <= '{clk_sync: 2'b00, sel_sync: 2'b11, sel_d: 1'b0,
                     state: SPS_ST_POWERUP, tick: 16'h0000, ms: 16'h0000,
                     period: INACT_RESET, eoo_pend: 1'b0, reply: 1'b0, miso: 1'b0};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign setup_reply_frame = s_r.reply;
    assign inactivity_period = s_r.period;
    assign resume_time = RESUME_RESET;
    assign power_save = (s_r.state == SPS_ST_SAVE);
    assign selected = (s_r.state == SPS_ST_SEL);
    assign ready_rx = selected;
    assign link.miso_o = s_r.miso;
    // Drive data only while selected and awake
    assign link.miso_oe_n = ~(selected && sel_now);
    // Request line held off in power save
    assign link.access_req_o = 1'b0;
    assign link.access_req_oe_n = ~(access_request && !power_save && !sel_now);
endmodule

// [sim/sps_link_asserts.sv]
// Checker for the power-save link between both ends
`timescale 1ns/10ps
module sps_link_asserts
    import sps_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic slave_select_n,
    input wire logic miso_oe_n,
    input wire logic access_req_oe_n,
    input wire logic setup_request_frame,
    input wire logic [15:0] req_inactivity_period,
    input wire logic setup_reply_frame,
    input wire logic [15:0] inactivity_period,
    input wire logic end_of_operation_acked,
    input wire logic access_request,
    input wire logic power_save,
    input wire logic selected
);
    // ==========================================
    // Properties, all in the system clock domain
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    property p_reply;
        setup_request_frame |=> setup_reply_frame;
    endproperty
    a_reply: assert property (p_reply) else $error("no setup reply");
    property p_echo;
        setup_request_frame && req_inactivity_period == INACT_NONE |=> inactivity_period == INACT_NONE;
    endproperty
    a_echo: assert property (p_echo) else $error("period not echoed");
    property p_never;
        inactivity_period == INACT_NONE && !power_save |=> !power_save;
    endproperty
    a_never: assert property (p_never) else $error("saving while declined");
    property p_quiet;
        power_save |-> miso_oe_n && access_req_oe_n;
    endproperty
    a_quiet: assert property (p_quiet) else $error("driving in power save");
    property p_eoo;
        end_of_operation_acked && !selected && !access_request && inactivity_period != INACT_NONE
            |-> ##[1:4] power_save;
    endproperty
    a_eoo: assert property (p_eoo) else $error("no save after end ack");
    property p_block;
        access_request && !power_save |=> !power_save;
    endproperty
    a_block: assert property (p_block) else $error("saving with request pending");
    property p_wake;
        $fell(slave_select_n) |-> ##[1:5] selected && !power_save;
    endproperty
    a_wake: assert property (p_wake) else $error("no resume on select");
    property p_desel;
        $rose(slave_select_n) |-> ##[1:5] !selected;
    endproperty
    a_desel: assert property (p_desel) else $error("not deselected");
    property p_mode0;
        slave_select_n |-> !link_clk;
    endproperty
    a_mode0: assert property (p_mode0) else $error("clock not idle low");
    property p_hold;
        $fell(slave_select_n) |-> !link_clk [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("clocked during resume");
    // High-phase length of the link clock, in system cycles
    logic [4:0] hi_cnt;
    // ==========================================
    // Helper counter, cleared while the clock is low
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            hi_cnt <= 5'h00;
        end
        else if (!link_clk)
        begin
            hi_cnt <= 5'h00;
        end
        else if (hi_cnt != 5'h1f)
        begin
            hi_cnt <= hi_cnt + 5'h01;
        end
    end
    property p_rate;
        $fell(link_clk) |-> hi_cnt == 5'(LINK_HALF_CYCLES);
    endproperty
    a_rate: assert property (p_rate) else $error("link clock not 1 MHz");
    // Main scenarios reached
    c_save: cover property ($rose(power_save));
    c_wake: cover property (power_save && $fell(slave_select_n));
    c_reply: cover property (setup_reply_frame);
endmodule

// [sim/test_spi_slave_power_save_control.sv]
// Testbench joining master end and slave end over the link
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_spi_slave_power_save_control;
    import sps_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic srq = 1'b0; // Setup request pulse
    logic [15:0] rqp = 16'hffff; // Requested period
    logic eoe = 1'b0; // End event pulse
    logic eoa = 1'b0; // End ack pulse
    logic areq = 1'b0; // Slave access request
    logic start = 1'b0; // Master start pulse
    logic fack = 1'b1; // Slave frames all acknowledged
    logic wsr; // Master saw slave request
    logic rep, ps, sel, rdy, busy;
    logic [15:0] per;
    logic [7:0] rt;
    int fail_count = 0;
    int checked = 0;
    sps_link_if link();
    sps_slave u_sps_slave (.clock(clock), .reset(reset), .link(link.slave_end),
        .setup_request_frame(srq), .req_inactivity_period(rqp), .setup_reply_frame(rep),
        .inactivity_period(per), .resume_time(rt), .end_of_operation_event(eoe),
        .end_of_operation_acked(eoa), .frames_acked(fack), .access_request(areq),
        .tx_bit(1'b1), .power_save(ps), .selected(sel), .ready_rx(rdy));
    sps_master u_sps_master (.clock(clock), .reset(reset), .link(link.master_end),
        .start(start), .resume_time(rt), .bit_count(8'h08), .tx_bit(1'b0), .busy(busy),
        .wake_seen_req(wsr));
    sps_link_asserts u_sps_link_asserts (.clock(clock), .reset(reset),
        .link_clk(link.link_clk), .slave_select_n(link.slave_select_n),
        .miso_oe_n(link.miso_oe_n), .access_req_oe_n(link.access_req_oe_n),
        .setup_request_frame(srq), .req_inactivity_period(rqp), .setup_reply_frame(rep),
        .inactivity_period(per), .end_of_operation_acked(eoa), .access_request(areq),
        .power_save(ps), .selected(sel));
    // 25 MHz clock
    initial forever #20 clock = ~clock;
    // Counts and verdict
    task summarize;
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // One master transfer; wakes or selects the slave
    task t_transfer;
        int lo;
        bit hi, s, r, d;
        lo = 0;
        hi = 0;
        s = 0;
        r = 0;
        d = 0;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        for (int n = 0; n < 6000 && busy === 1'b1; n++)
        begin
            tick(1);
            if (sel === 1'b1)
                s = 1;
            if (link.miso_oe_n === 1'b0 && link.miso_o === 1'b1)
                d = 1;
            if (link.link_clk === 1'b1)
            begin
                hi = 1;
                r = r | (rdy === 1'b1);
            end
            else if (!hi && link.slave_select_n === 1'b0)
                lo++;
        end
        `CHK("selected", 1'b1, s)
        `CHK("resume hold", 1'b1, hi && lo >= int'(RESUME_RESET) * 25)
        `CHK("ready rx", 1'b1, r)
        `CHK("data out", 1'b1, d)
        tick(8);
        `CHK("deselected", 1'b0, sel)
        `CHK("awake", 1'b0, ps)
        $display("test transfer done");
    endtask
    // Setup request, reply and echo
    task t_setup(input logic [15:0] v);
        logic got;
        rqp = v;
        srq = 1'b1;
        tick(1);
        srq = 1'b0;
        got = rep;
        tick(1);
        got = got | rep;
        `CHK("setup reply", 1'b1, got)
        if (v == INACT_NONE)
        begin
            `CHK("declined period", INACT_NONE, per)
        end
        tick(100);
        `CHK("save after setup", 1'b0, ps)
        $display("test setup done");
    endtask
    // End of operation acknowledged leads to power save
    task t_eoo;
        t_setup(16'h0100);
        eoe = 1'b1;
        tick(1);
        eoe = 1'b0;
        tick(2);
        eoa = 1'b1;
        tick(1);
        eoa = 1'b0;
        tick(6);
        `CHK("save after ack", 1'b1, ps)
        `CHK("data released", 1'b1, link.miso_oe_n)
        `CHK("request released", 1'b1, link.access_req_oe_n)
        t_transfer();
        $display("test end of operation done");
    endtask
    // Inactivity with and without pending request
    task t_inact;
        t_setup(16'h0001);
        areq = 1'b1;
        tick(30000);
        `CHK("blocked save", 1'b0, ps)
        `CHK("request seen", 1'b1, wsr)
        areq = 1'b0;
        fack = 1'b0;
        tick(4);
        `CHK("unacked save", 1'b0, ps)
        fack = 1'b1;
        for (int n = 0; n < 60000 && ps !== 1'b1; n++)
            tick(1);
        `CHK("idle save", 1'b1, ps)
        t_transfer();
        `CHK("request dropped", 1'b0, wsr)
        $display("test inactivity done");
    endtask
    // Bounded run time
    initial
    begin
        #(90000 * 40);
        fail_count++;
        summarize();
    end
    initial
    begin
        tick(10);
        reset = 1'b0;
        tick(2);
        `CHK("reset save", 1'b0, ps)
        `CHK("reset period", INACT_RESET, per)
        `CHK("reset clock", 1'b0, link.link_clk)
        `CHK("resume time", RESUME_RESET, rt)
        t_transfer();
        t_setup(INACT_NONE);
        t_eoo();
        t_inact();
        summarize();
    end
endmodule
